// ==== pis_top.sv ====
// Interrupt sources, controller gating and exception vector entry.
//
// Contract
// - Exception table has eight word entries; reset first, IRQ seventh at 0x18.
// - On an exception, stop and fetch from that exception's table entry.
// - Controller enables each source individually; enabled request raises IRQ exception.
// - Numbers: private timer 29, processor GPIO 197, system timers 199 to 202.
// - Fabric numbers: 72,73,74 timers/keys, 80 UART, 83,84,85 ports.
// - Private timer flags expiry at zero; interrupts while its enable is 1.
// - System timer at zero sets end-of-interrupt flag, mirrored in status.
// - System timer mask is active high; 0 lets the flag interrupt.
// - Reading the end-of-interrupt register clears the flag and its interrupt.
// - Interval timer sets timeout at zero; interrupts when timeout enable is 1.
// - Any write to interval timer status clears a pending timeout.
// - Parallel port mask at offset 8; bit 1 allows, 0 blocks interrupts.
// - Edge capture at offset C records each 0 to 1 input change.
// - Any write to edge capture zeroes it and withdraws its interrupts.
// - Pushbutton press sets its capture bit; interrupts if mask bit is 1.
// - UART control holds receive and transmit interrupt enable bits.
// - Enabled UART interrupts when stored count or free space exceeds 7.
// - UART shows pending interrupts in control bits, clearing as data moves.
// - UART data read returns receive count in bits 31 to 16.
// - UART control read returns free transmit space in bits 31 to 16.
`timescale 1ns/1ps
module pis_top
  import pis_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        exc_req,
  input  wire logic [2:0]                  exc_type,
  input  wire logic                        exc_return,
  output logic [31:0]                      fetch_addr,
  output logic                             fetch_go,
  output logic                             in_handler,
  input  wire logic [SRC_N-1:0]            irq_enable,
  output logic [SRC_N-1:0]                 src_irq,
  output logic                             cpu_irq,
  output logic [ID_W-1:0]                  irq_id,
  input  wire logic                        ptmr_zero,
  input  wire logic                        ptmr_irq_en,
  input  wire logic                        ptmr_status_wr,
  input  wire logic                        ptmr_status_wdata,
  output logic                             ptmr_expired,
  input  wire logic [NUM_ST-1:0]           st_zero,
  input  wire logic [NUM_ST-1:0]           st_mask,
  input  wire logic [NUM_ST-1:0]           st_eoi_rd,
  output logic [NUM_ST-1:0]                st_flag,
  input  wire logic [NUM_IT-1:0]           it_zero,
  input  wire logic [NUM_IT-1:0]           interrupt_on_timeout_enable,
  input  wire logic [NUM_IT-1:0]           it_status_wr,
  output logic [NUM_IT-1:0]                interval_timeout_flag,
  input  wire logic                        gpio_irq,
  input  wire logic [NUM_PP-1:0][PP_W-1:0] pp_in,
  input  wire pis_pp_req_s                 pp_req,
  output logic [PP_W-1:0]                  pp_rdata,
  input  wire pis_uart_req_s               uart_req,
  input  wire pis_uart_stat_s              uart_stat,
  output logic [31:0]                      uart_rdata,
  output logic                             rx_irq_pending,
  output logic                             tx_irq_pending
);

  pis_state_s s_q;
  pis_state_s s_d;
  logic [SRC_N-1:0] active;

  // Interrupt levels.
  // level interrupt outputs
  assign src_irq[SRC_PTMR] = s_q.ptmr_f & ptmr_irq_en;
  assign src_irq[SRC_GPIO] = gpio_irq;

  for (genvar i = 0; i < NUM_ST; i++) begin : g_st
    assign src_irq[SRC_ST0+i] = s_q.st_f[i] & ~st_mask[i];
  end

  for (genvar i = 0; i < NUM_IT; i++) begin : g_it
    assign src_irq[IT_SRC[i]] = s_q.it_to[i] & interrupt_on_timeout_enable[i];
  end

  for (genvar i = 0; i < NUM_PP; i++) begin : g_pp
    assign src_irq[PP_SRC[i]] = |(s_q.pp_edge[i] & s_q.pp_mask[i]);
  end

  // The pending bits follow the counts, so moving data clears them at once.
  // threshold above seven
  assign rx_irq_pending = s_q.rx_irq_enable & (uart_stat.rx_chars_stored > UART_IRQ_LEVEL);
  assign tx_irq_pending = s_q.tx_irq_enable & (uart_stat.tx_space_free > UART_IRQ_LEVEL);
  assign src_irq[SRC_UART] = rx_irq_pending | tx_irq_pending;

  assign active  = src_irq & irq_enable;
  assign cpu_irq = |active;

  always_comb begin
    logic [PP_W-1:0] rise;
    logic            hit;
    rise = '0;
    hit  = 1'b0;
    s_d  = s_q;
    s_d.fetch_go = 1'b0;

    // A new event outranks a clear arriving in the same cycle.
    // expiry sets flag
    if (ptmr_zero) begin
      s_d.ptmr_f = 1'b1;
    end else if (ptmr_status_wr && ptmr_status_wdata) begin
      s_d.ptmr_f = 1'b0;
    end

    for (int i = 0; i < NUM_ST; i++) begin
      if (st_zero[i]) begin
        s_d.st_f[i] = 1'b1;
      end else if (st_eoi_rd[i]) begin
        s_d.st_f[i] = 1'b0;
      end
    end

    for (int i = 0; i < NUM_IT; i++) begin
      if (it_zero[i]) begin
        s_d.it_to[i] = 1'b1;
      end else if (it_status_wr[i]) begin
        s_d.it_to[i] = 1'b0;
      end
    end

    s_d.pp_rdata = '0;
    for (int i = 0; i < NUM_PP; i++) begin
      rise = pp_in[i] & ~s_q.pp_prev[i];
      hit  = (pp_req.sel == 2'(i));
      s_d.pp_prev[i] = pp_in[i];
      if (hit && pp_req.wr && pp_req.off == PP_OFF_MASK) begin
        s_d.pp_mask[i] = pp_req.wdata;
      end
      if (hit && pp_req.wr && pp_req.off == PP_OFF_EDGE) begin
        s_d.pp_edge[i] = rise;
      end else begin
        s_d.pp_edge[i] = s_q.pp_edge[i] | rise;
      end
      if (hit && pp_req.rd) begin
        unique case (pp_req.off)
          PP_OFF_DATA: s_d.pp_rdata = pp_in[i];
          PP_OFF_MASK: s_d.pp_rdata = s_q.pp_mask[i];
          PP_OFF_EDGE: s_d.pp_rdata = s_q.pp_edge[i];
          default:     s_d.pp_rdata = '0;
        endcase
      end
    end

    if (uart_req.wr && uart_req.reg_sel == UART_SEL_CTRL) begin
      s_d.rx_irq_enable = uart_req.wdata[UART_RX_EN_BIT];
      s_d.tx_irq_enable = uart_req.wdata[UART_TX_EN_BIT];
    end
    s_d.uart_rdata = '0;
    if (uart_req.rd) begin
      if (uart_req.reg_sel == UART_SEL_DATA) begin
        s_d.uart_rdata[31:UART_CNT_LSB] = uart_stat.rx_chars_stored;
        s_d.uart_rdata[UART_RVALID_BIT] = |uart_stat.rx_chars_stored;
        s_d.uart_rdata[7:0] = uart_stat.rx_char;
      end else begin
        s_d.uart_rdata[31:UART_CNT_LSB] = uart_stat.tx_space_free;
        s_d.uart_rdata[UART_RX_PEND_BIT] = rx_irq_pending;
        s_d.uart_rdata[UART_TX_PEND_BIT] = tx_irq_pending;
        s_d.uart_rdata[UART_RX_EN_BIT]   = s_q.rx_irq_enable;
        s_d.uart_rdata[UART_TX_EN_BIT]   = s_q.tx_irq_enable;
      end
    end

    // Lowest interrupt number wins when several are active.
    // processor side numbers
    s_d.irq_id = '0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (active[i]) begin
        s_d.irq_id = SRC_ID[i];
      end
    end

    // An explicit exception always wins; an IRQ is not nested into a handler.
    // stop and vector
    unique case (s_q.exc)
      EXC_RUN: begin
        if (exc_req) begin
          s_d.fetch_addr = VEC_BASE + 32'({exc_type, VEC_WORD_PAD});
          s_d.fetch_go   = 1'b1;
          s_d.exc        = EXC_HANDLER;
        end else if (cpu_irq) begin
          s_d.fetch_addr = VEC_BASE + 32'({VEC_IRQ, VEC_WORD_PAD});
          s_d.fetch_go   = 1'b1;
          s_d.exc        = EXC_HANDLER;
        end
      end
      EXC_HANDLER: begin
        if (exc_req) begin
          s_d.fetch_addr = VEC_BASE + 32'({exc_type, VEC_WORD_PAD});
          s_d.fetch_go   = 1'b1;
        end else if (exc_return) begin
          s_d.exc = EXC_RUN;
        end
      end
      default: begin
        s_d.exc = EXC_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q.exc           <= EXC_RUN;
      s_q.fetch_addr    <= VEC_BASE + 32'({VEC_RESET, VEC_WORD_PAD});
      s_q.fetch_go      <= 1'b0;
      s_q.ptmr_f        <= 1'b0;
      s_q.st_f          <= '0;
      s_q.it_to         <= '0;
      s_q.pp_mask       <= {NUM_PP{PP_MASK_RST}};
      s_q.pp_edge       <= {NUM_PP{PP_EDGE_RST}};
      s_q.pp_prev       <= '0;
      s_q.pp_rdata      <= '0;
      s_q.uart_rdata    <= '0;
      s_q.rx_irq_enable <= 1'b0;
      s_q.tx_irq_enable <= 1'b0;
      s_q.irq_id        <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fetch_addr            = s_q.fetch_addr;
  assign fetch_go              = s_q.fetch_go;
  assign in_handler            = (s_q.exc == EXC_HANDLER);
  assign irq_id                = s_q.irq_id;
  assign ptmr_expired          = s_q.ptmr_f;
  assign st_flag               = s_q.st_f;
  assign interval_timeout_flag = s_q.it_to;
  assign pp_rdata              = s_q.pp_rdata;
  assign uart_rdata            = s_q.uart_rdata;

endmodule

// ==== pis_pkg.sv ====
// Constants, types and state layout for the peripheral interrupt sources block.
package pis_pkg;

  localparam int NUM_ST  = 4;
  localparam int NUM_IT  = 2;
  localparam int NUM_PP  = 4;
  localparam int PP_W    = 32;
  localparam int ID_W    = 8;
  localparam int SRC_N   = 13;
  localparam int VEC_N   = 8;

  // Exception table: eight word entries, IRQ entry is the seventh.
  localparam logic [31:0] VEC_BASE     = 32'h0000_0000;
  localparam logic [2:0]  VEC_RESET    = 3'h0;
  localparam logic [2:0]  VEC_IRQ      = 3'h6;
  localparam logic [1:0]  VEC_WORD_PAD = 2'h0;

  // Parallel port register offsets.
  localparam logic [3:0] PP_OFF_DATA = 4'h0;
  localparam logic [3:0] PP_OFF_MASK = 4'h8;
  localparam logic [3:0] PP_OFF_EDGE = 4'hc;
  localparam logic [PP_W-1:0] PP_MASK_RST = 32'h0000_0000;
  localparam logic [PP_W-1:0] PP_EDGE_RST = 32'h0000_0000;

  // Debug UART register selects and field positions.
  localparam logic       UART_SEL_DATA   = 1'b0;
  localparam logic       UART_SEL_CTRL   = 1'b1;
  localparam logic [15:0] UART_IRQ_LEVEL = 16'h0007;
  localparam int UART_RX_EN_BIT   = 0;
  localparam int UART_TX_EN_BIT   = 1;
  localparam int UART_RX_PEND_BIT = 8;
  localparam int UART_TX_PEND_BIT = 9;
  localparam int UART_RVALID_BIT = 15;
  localparam int UART_CNT_LSB    = 16;

  // Source indices, ordered by ascending interrupt number.
  localparam int SRC_PTMR = 0;
  localparam int SRC_UART = 4;
  localparam int SRC_GPIO = 8;
  localparam int SRC_ST0  = 9;
  localparam int IT_SRC [NUM_IT] = '{1, 3};
  localparam int PP_SRC [NUM_PP] = '{2, 5, 6, 7};

  // Interrupt numbers at the controller, index 0 last.
  localparam logic [SRC_N-1:0][ID_W-1:0] SRC_ID = {
    8'hca, 8'hc9, 8'hc8, 8'hc7, 8'hc5, 8'h55, 8'h54,
    8'h53, 8'h50, 8'h4a, 8'h49, 8'h48, 8'h1d};

  typedef enum logic [1:0] {
    EXC_RUN     = 2'b01,
    EXC_HANDLER = 2'b10
  } pis_exc_e;

  typedef struct packed {
    logic [1:0]      sel;
    logic            wr;
    logic            rd;
    logic [3:0]      off;
    logic [PP_W-1:0] wdata;
  } pis_pp_req_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        reg_sel;
    logic [31:0] wdata;
  } pis_uart_req_s;

  typedef struct packed {
    logic [15:0] rx_chars_stored;
    logic [15:0] tx_space_free;
    logic [7:0]  rx_char;
  } pis_uart_stat_s;

  typedef struct packed {
    pis_exc_e                     exc;
    logic [31:0]                  fetch_addr;
    logic                         fetch_go;
    logic                         ptmr_f;
    logic [NUM_ST-1:0]            st_f;
    logic [NUM_IT-1:0]            it_to;
    logic [NUM_PP-1:0][PP_W-1:0]  pp_mask;
    logic [NUM_PP-1:0][PP_W-1:0]  pp_edge;
    logic [NUM_PP-1:0][PP_W-1:0]  pp_prev;
    logic [PP_W-1:0]              pp_rdata;
    logic [31:0]                  uart_rdata;
    logic                         rx_irq_enable;
    logic                         tx_irq_enable;
    logic [ID_W-1:0]              irq_id;
  } pis_state_s;

endpackage

// ==== pis_chk.sv ====
// Concurrent checks on the interrupt sources top-level ports.
`timescale 1ns/1ps
module pis_chk
  import pis_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              exc_req,
  input wire logic [2:0]        exc_type,
  input wire logic [31:0]       fetch_addr,
  input wire logic              fetch_go,
  input wire logic              in_handler,
  input wire logic [SRC_N-1:0]  irq_enable,
  input wire logic [SRC_N-1:0]  src_irq,
  input wire logic              cpu_irq,
  input wire logic              ptmr_zero,
  input wire logic              ptmr_irq_en,
  input wire logic              ptmr_status_wr,
  input wire logic              ptmr_status_wdata,
  input wire logic              ptmr_expired,
  input wire logic [NUM_ST-1:0] st_zero,
  input wire logic [NUM_ST-1:0] st_mask,
  input wire logic [NUM_ST-1:0] st_eoi_rd,
  input wire logic [NUM_ST-1:0] st_flag,
  input wire logic [NUM_IT-1:0] it_zero,
  input wire logic [NUM_IT-1:0] it_status_wr,
  input wire logic [NUM_IT-1:0] interval_timeout_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_fetch(logic [31:0] a);
    fetch_go && in_handler && fetch_addr == a;
  endsequence
  property p_irq_vec;
    cpu_irq && !in_handler && !exc_req |=> s_fetch(32'h0000_0018);
  endproperty
  property p_exc_vec;
    exc_req |=> s_fetch({27'h0, $past(exc_type), 2'h0});
  endproperty
  property p_cpu_or;
    cpu_irq == |(src_irq & irq_enable);
  endproperty
  property p_ptmr_set;
    ptmr_zero |=> ptmr_expired;
  endproperty
  property p_ptmr_clr;
    ptmr_status_wr && ptmr_status_wdata && !ptmr_zero |=> !ptmr_expired;
  endproperty
  property p_st_mask;
    src_irq[SRC_ST0] == (st_flag[0] && !st_mask[0]);
  endproperty
  property p_st_eoi;
    st_eoi_rd[0] && !st_zero[0] |=> !st_flag[0] && !src_irq[SRC_ST0];
  endproperty
  property p_it_set;
    $rose(interval_timeout_flag[1]) |-> $past(it_zero[1]);
  endproperty
  property p_it_clr;
    it_status_wr[1] && !it_zero[1] |=> !interval_timeout_flag[1];
  endproperty
  property p_ptmr_src;
    src_irq[SRC_PTMR] == (ptmr_expired && ptmr_irq_en);
  endproperty
  property p_no_nest;
    in_handler && !exc_req |=> !fetch_go;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("irq entry not at 0x18");
  a_exc_vec: assert property (p_exc_vec) else $error("wrong vector fetch");
  a_cpu_or: assert property (p_cpu_or) else $error("cpu irq gating wrong");
  a_ptmr_set: assert property (p_ptmr_set) else $error("timer flag not set");
  a_ptmr_clr: assert property (p_ptmr_clr) else $error("timer flag not cleared");
  a_st_mask: assert property (p_st_mask) else $error("system timer mask wrong");
  a_st_eoi: assert property (p_st_eoi) else $error("eoi read did not clear");
  a_it_set: assert property (p_it_set) else $error("timeout rose without zero");
  a_it_clr: assert property (p_it_clr) else $error("timeout not cleared");
  a_ptmr_src: assert property (p_ptmr_src) else $error("private timer level wrong");
  a_no_nest: assert property (p_no_nest) else $error("irq taken inside handler");
endmodule

bind pis_top pis_chk chk_u (.*);

// ==== pis_cpu_model.sv ====
// Processor-side model that stays in the handler for a while and then returns.
`timescale 1ns/1ps
module pis_cpu_model #(
  parameter int DWELL = 5
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic in_handler,
  output logic      exc_return
);
  int cnt = 0;
  always @(negedge core_clk) begin
    exc_return <= 1'b0;
    if (rst || !in_handler) begin
      cnt <= 0;
    end else if (cnt == DWELL) begin
      exc_return <= 1'b1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ==== pis_test.sv ====
// Self-checking bench for the peripheral interrupt sources block.
`timescale 1ns/1ps
module pis_test
  import pis_pkg::*;
;
  logic                        core_clk = 1'b0, rst = 1'b1, exc_req = 1'b0, exc_return;
  logic [2:0]                  exc_type = 3'h0;
  logic [31:0]                 fetch_addr, uart_rdata, rd;
  logic                        fetch_go, in_handler, cpu_irq, gpio_irq = 1'b0;
  logic [SRC_N-1:0]            irq_enable = '0, src_irq;
  logic [ID_W-1:0]             irq_id;
  logic                        ptmr_zero = 1'b0, ptmr_irq_en = 1'b0, ptmr_expired;
  logic                        ptmr_status_wr = 1'b0, ptmr_status_wdata = 1'b0;
  logic [NUM_ST-1:0]           st_zero = '0, st_mask = '1, st_eoi_rd = '0, st_flag;
  logic [NUM_IT-1:0]           it_zero = '0, interrupt_on_timeout_enable = '0;
  logic [NUM_IT-1:0]           it_status_wr = '0, interval_timeout_flag;
  logic [NUM_PP-1:0][PP_W-1:0] pp_in = '0;
  logic [PP_W-1:0]             pp_rdata;
  pis_pp_req_s                 pp_req = '0;
  pis_uart_req_s               uart_req = '0;
  pis_uart_stat_s              uart_stat = '0;
  logic                        rx_irq_pending, tx_irq_pending;
  int                          err_total = 0, n_tests = 0;

  pis_top dut_u (.*);
  pis_cpu_model #(.DWELL(5)) cpu_u (.core_clk(core_clk), .rst(rst),
    .in_handler(in_handler), .exc_return(exc_return));
  always #2 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask
  // Read data stands for one cycle only, so it is captured at the first negedge.
  task automatic pp_acc(input logic wr, input logic [3:0] off, input logic [31:0] d);
    pp_req = '{sel: 2'h0, wr: wr, rd: ~wr, off: off, wdata: d};
    step();
    rd = pp_rdata;
    pp_req = '0;
    step();
  endtask
  task automatic uart_acc(input logic wr, input logic sel, input logic [31:0] d);
    uart_req = '{wr: wr, rd: ~wr, reg_sel: sel, wdata: d};
    step();
    rd = uart_rdata;
    uart_req = '0;
    step();
  endtask

  initial begin
    #20000;
    err_total++;
    test_done();
  end

  initial begin
    step(12);
    rst = 1'b0;
    chk("fetch_addr", fetch_addr, 32'h0);
    for (int t = 0; t < VEC_N; t++) begin
      exc_type = t[2:0];
      pulse(exc_req);
      chk("fetch_addr", fetch_addr, 32'(t * 4));
      chk("fetch_go", 32'(fetch_go), 32'h1);
      step(10);
    end
    irq_enable[SRC_PTMR] = 1'b1;
    ptmr_irq_en = 1'b1;
    pulse(ptmr_zero);
    chk("ptmr_expired", 32'(ptmr_expired), 32'h1);
    chk("cpu_irq", 32'(cpu_irq), 32'h1);
    step();
    chk("fetch_addr", fetch_addr, 32'h0000_0018);
    chk("irq_id", 32'(irq_id), 32'h1d);
    ptmr_status_wdata = 1'b0;
    pulse(ptmr_status_wr);
    step();
    chk("ptmr_expired", 32'(ptmr_expired), 32'h1);
    ptmr_status_wdata = 1'b1;
    pulse(ptmr_status_wr);
    step();
    chk("ptmr_expired", 32'(ptmr_expired), 32'h0);
    irq_enable = '0;
    step(10);
    st_zero = 4'h1;
    step();
    st_zero = 4'h0;
    chk("st_flag", 32'(st_flag), 32'h1);
    chk("st_src", 32'(src_irq[SRC_ST0]), 32'h0);
    st_mask = 4'he;
    irq_enable[SRC_ST0] = 1'b1;
    step();
    chk("st_src", 32'(src_irq[SRC_ST0]), 32'h1);
    chk("irq_id", 32'(irq_id), 32'hc7);
    st_eoi_rd = 4'h1;
    step();
    st_eoi_rd = 4'h0;
    chk("st_src", 32'(src_irq[SRC_ST0]), 32'h0);
    irq_enable = '0;
    interrupt_on_timeout_enable = 2'h2;
    it_zero = 2'h2;
    step();
    it_zero = 2'h0;
    chk("it_src", 32'(src_irq[IT_SRC[1]]), 32'h1);
    it_status_wr = 2'h2;
    step();
    it_status_wr = 2'h0;
    chk("it_flag", 32'(interval_timeout_flag), 32'h0);
    pp_acc(1'b1, PP_OFF_MASK, 32'h2);
    pp_in[0] = 32'h2;
    step();
    chk("key_src", 32'(src_irq[PP_SRC[0]]), 32'h1);
    irq_enable[PP_SRC[0]] = 1'b1;
    step();
    chk("irq_id", 32'(irq_id), 32'h49);
    irq_enable = '0;
    pp_acc(1'b0, PP_OFF_MASK, 32'h0);
    chk("pp_mask", rd, 32'h2);
    pp_acc(1'b0, PP_OFF_EDGE, 32'h0);
    chk("pp_edge", rd, 32'h2);
    pp_acc(1'b1, PP_OFF_EDGE, 32'h0);
    chk("key_src", 32'(src_irq[PP_SRC[0]]), 32'h0);
    pp_in[0] = 32'h3;
    step(2);
    chk("key_src", 32'(src_irq[PP_SRC[0]]), 32'h0);
    pp_acc(1'b0, 4'h4, 32'h0);
    chk("pp_unmapped", rd, 32'h0);
    uart_stat = '{rx_chars_stored: 16'h8, tx_space_free: 16'h7, rx_char: 8'h41};
    uart_acc(1'b1, UART_SEL_CTRL, 32'h3);
    chk("rx_pend", 32'(rx_irq_pending), 32'h1);
    chk("tx_pend", 32'(tx_irq_pending), 32'h0);
    uart_acc(1'b0, UART_SEL_CTRL, 32'h0);
    chk("uart_ctrl", rd, 32'h0007_0103);
    uart_acc(1'b0, UART_SEL_DATA, 32'h0);
    chk("uart_data", rd, 32'h0008_8041);
    uart_stat = '{rx_chars_stored: 16'h7, tx_space_free: 16'h8, rx_char: 8'h41};
    step();
    chk("pend", 32'({rx_irq_pending, tx_irq_pending}), 32'h1);
    uart_acc(1'b1, UART_SEL_CTRL, 32'h0);
    chk("uart_src", 32'(src_irq[SRC_UART]), 32'h0);
    gpio_irq = 1'b1;
    irq_enable[SRC_GPIO] = 1'b1;
    step();
    chk("gpio_src", 32'(src_irq[SRC_GPIO]), 32'h1);
    chk("irq_id", 32'(irq_id), 32'hc5);
    test_done();
  end
endmodule
